// ### rtl/sdms_top.sv
`timescale 1ns/1ns
`include "sdms_defs.svh"
// Summary of operation
// - dual modes 06, 07, 0A chosen by input
// - no zero-command variants inside dual modes
// - pos/speed: pulse position, analog or preset speed
// - speed/torque: select pairs pick analog or preset
// - select on means torque, off means speed
// - return to torque immediately, no delay
// - pos/torque: pulse position, analog or preset torque
// - max speed parameter caps speed everywhere
// - speed limit sourced like speed command
// - speed limit only torque mode, when enabled
// - speed-select pair picks limit, else analog
// - torque limit sourced like torque command
// - torque limit only position and speed modes
// - torque enable bit validates torque-select inputs
// - torque-select pair picks limit, else analog
// - two monitor channels, select 00 to 77
// - selects off: analog or zero; else presets
// - monitor digit codes 0 to 5, 6-7 reserved
module sdms_top #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // mode configuration
  input wire logic [7:0] control_mode,
  input wire logic zero_speed_variant,
  input wire logic zero_torque_variant,
  input wire logic [1:0] limit_enable_config,
  input wire logic signed [W-1:0] max_speed_param,
  // digital inputs from the controller
  input wire logic mode_switch_in,
  input wire logic [1:0] speed_preset_sel,
  input wire logic [1:0] torque_preset_sel,
  // command sources
  input wire logic signed [W-1:0] pulse_position_cmd,
  input wire logic signed [W-1:0] analog_speed_in,
  input wire logic signed [W-1:0] analog_torque_in,
  input wire logic signed [W-1:0] speed_preset_params_0,
  input wire logic signed [W-1:0] speed_preset_params_1,
  input wire logic signed [W-1:0] speed_preset_params_2,
  input wire logic signed [W-1:0] torque_preset_params_0,
  input wire logic signed [W-1:0] torque_preset_params_1,
  input wire logic signed [W-1:0] torque_preset_params_2,
  // monitor sources
  input wire logic signed [W-1:0] motor_speed,
  input wire logic signed [W-1:0] motor_torque,
  input wire logic signed [W-1:0] pulse_freq,
  input wire logic signed [W-1:0] bus_volt,
  // parameter port
  input wire logic param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  output logic [15:0] param_rdata,
  // results
  output sdms_pkg::sdms_ctrl_t active_mode,
  output logic pulse_position_mode,
  output logic signed [W-1:0] position_cmd,
  output logic signed [W-1:0] speed_cmd,
  output logic signed [W-1:0] torque_cmd,
  output logic signed [W-1:0] speed_limit,
  output logic speed_limit_active,
  output logic signed [W-1:0] torque_limit,
  output logic torque_limit_active,
  output logic signed [W-1:0] max_speed_limit,
  output logic signed [W-1:0] monitor1,
  output logic signed [W-1:0] monitor2
);
  import sdms_pkg::*;
  logic rst_s1_r;
  logic rst_s2_r;
  logic [4:0] din_s1_r;
  logic [4:0] din_s2_r;
  logic [15:0] mon_sel_r;
  logic [15:0] mon_sel_nxt;
  sdms_ctrl_t mode_r;
  sdms_ctrl_t mode_nxt;
  logic signed [W-1:0] pos_r;
  logic signed [W-1:0] spd_r;
  logic signed [W-1:0] trq_r;
  logic signed [W-1:0] spd_lim_r;
  logic signed [W-1:0] trq_lim_r;
  logic spd_lim_act_r;
  logic trq_lim_act_r;
  logic signed [W-1:0] mon1_r;
  logic signed [W-1:0] mon2_r;
  logic ppm_r;
  logic signed [W-1:0] msl_r;

  // reset release through two flops
  // assertion stays asynchronous so the outputs other than max_speed_limit take their reset values without a clock (pulse_position_mode sets, the rest clear)
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire rst_n = rst_s2_r;

  // digital inputs are pins: two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_r <= 5'h00;
      din_s2_r <= 5'h00;
    end else begin
      din_s1_r <= {mode_switch_in, speed_preset_sel, torque_preset_sel};
      din_s2_r <= din_s1_r;
    end
  end

  wire sw_on = din_s2_r[4];
  wire [1:0] spd_sel = din_s2_r[3:2];
  wire [1:0] trq_sel = din_s2_r[1:0];

  wire is_pt_s = (control_mode == `SDMS_MODE_PT_S);
  wire is_pt_t = (control_mode == `SDMS_MODE_PT_T);
  wire is_s_t = (control_mode == `SDMS_MODE_S_T);
  wire is_dual = is_pt_s | is_pt_t | is_s_t;
  // any other code is a single mode: the mode register then holds

  // dual modes never use the zero-command variants
  wire spd_zero = zero_speed_variant & ~is_dual;
  wire trq_zero = zero_torque_variant & ~is_dual;

  // mode decision is combinational so a switch lands on the next update
  always_comb begin
    mode_nxt = mode_r;
    case (1'b1)
      is_pt_s: mode_nxt = sw_on ? SDMS_CTRL_SPD : SDMS_CTRL_POS;
      is_pt_t: mode_nxt = sw_on ? SDMS_CTRL_TRQ : SDMS_CTRL_POS;
      is_s_t: mode_nxt = sw_on ? SDMS_CTRL_TRQ : SDMS_CTRL_SPD;
      default: mode_nxt = mode_r;
    endcase
  end

  wire signed [W-1:0] spd_src;
  wire signed [W-1:0] trq_src;

  // speed command, also the speed limit source
  sdms_cmd_sel #(.W(W)) u_spd_sel (
    .sel(spd_sel),
    .zero_variant(spd_zero),
    .analog_in(analog_speed_in),
    .preset0(speed_preset_params_0),
    .preset1(speed_preset_params_1),
    .preset2(speed_preset_params_2),
    .cmd(spd_src)
  );

  // torque command, also the torque limit source
  sdms_cmd_sel #(.W(W)) u_trq_sel (
    .sel(trq_sel),
    .zero_variant(trq_zero),
    .analog_in(analog_torque_in),
    .preset0(torque_preset_params_0),
    .preset1(torque_preset_params_1),
    .preset2(torque_preset_params_2),
    .cmd(trq_src)
  );

  // limits gate on mode and enable bits
  wire spd_lim_en = limit_enable_config[`SDMS_LIM_SPD_EN_BIT];
  wire trq_lim_en = limit_enable_config[`SDMS_LIM_TRQ_EN_BIT];
  wire spd_lim_act_nxt = spd_lim_en & (mode_nxt == SDMS_CTRL_TRQ);
  wire trq_lim_act_nxt = trq_lim_en & (mode_nxt != SDMS_CTRL_TRQ);
  // disabled torque limit ignores the selects: analog passes as plain limit
  wire signed [W-1:0] trq_lim_nxt = trq_lim_en ? trq_src : analog_torque_in;

  // magnitude clamp by max speed
  // both signs clamped, so a reversed command cannot exceed the cap
  wire signed [W-1:0] spd_neg_max = -max_speed_param;
  wire signed [W-1:0] spd_clamped = (spd_src > max_speed_param) ? max_speed_param :
                                    (spd_src < spd_neg_max) ? spd_neg_max : spd_src;

  // in dual modes only the current command source is updated; single modes always update speed and torque
  wire upd_pos = (mode_nxt == SDMS_CTRL_POS);
  wire upd_spd = (mode_nxt == SDMS_CTRL_SPD) | ~is_dual;
  wire upd_trq = (mode_nxt == SDMS_CTRL_TRQ) | ~is_dual;

  // idle commands hold so a switch back resumes from the last value
  wire signed [W-1:0] pos_nxt = upd_pos ? pulse_position_cmd : pos_r;
  wire signed [W-1:0] spd_nxt = upd_spd ? spd_clamped : spd_r;
  wire signed [W-1:0] trq_nxt = upd_trq ? trq_src : trq_r;
  // speed limit shares the clamped speed source
  wire signed [W-1:0] spd_lim_nxt = spd_clamped;
  // flag taken from the next mode so it never lags active_mode
  wire ppm_nxt = (mode_nxt == SDMS_CTRL_POS);

  // monitor select register, reserved bits held at zero
  // bits outside the two digits always read back as zero
  wire mon_hit = param_wr & (param_addr == `SDMS_MON_SEL_OFFSET);
  assign mon_sel_nxt = mon_hit ? (param_wdata & `SDMS_MON_SEL_MASK) : mon_sel_r;

  wire [2:0] mon1_src = mon_sel_r[`SDMS_MON1_LSB +: 3];
  wire [2:0] mon2_src = mon_sel_r[`SDMS_MON2_LSB +: 3];
  wire signed [W-1:0] mon1_val;
  wire signed [W-1:0] mon2_val;

  sdms_mon_mux #(.W(W)) u_mon1 (
    .src(mon1_src),
    .motor_speed(motor_speed),
    .motor_torque(motor_torque),
    .pulse_freq(pulse_freq),
    .speed_cmd(spd_r),
    .torque_cmd(trq_r),
    .bus_volt(bus_volt),
    .value(mon1_val)
  );

  sdms_mon_mux #(.W(W)) u_mon2 (
    .src(mon2_src),
    .motor_speed(motor_speed),
    .motor_torque(motor_torque),
    .pulse_freq(pulse_freq),
    .speed_cmd(spd_r),
    .torque_cmd(trq_r),
    .bus_volt(bus_volt),
    .value(mon2_val)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= SDMS_CTRL_POS;
      mon_sel_r <= `SDMS_MON_SEL_RESET;
    end else begin
      mode_r <= mode_nxt;
      mon_sel_r <= mon_sel_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= '0;
      spd_r <= '0;
      trq_r <= '0;
    end else begin
      pos_r <= pos_nxt;
      spd_r <= spd_nxt;
      trq_r <= trq_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spd_lim_r <= '0;
      trq_lim_r <= '0;
      spd_lim_act_r <= 1'b0;
      trq_lim_act_r <= 1'b0;
    end else begin
      spd_lim_r <= spd_lim_nxt;
      trq_lim_r <= trq_lim_nxt;
      spd_lim_act_r <= spd_lim_act_nxt;
      trq_lim_act_r <= trq_lim_act_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon1_r <= '0;
      mon2_r <= '0;
    end else begin
      mon1_r <= mon1_val;
      mon2_r <= mon2_val;
    end
  end

  // flag registered alongside the mode it mirrors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ppm_r <= 1'b1;
    end else begin
      ppm_r <= ppm_nxt;
    end
  end

  // no reset: the cap follows its parameter from the first edge on
  always_ff @(posedge clk) begin
    msl_r <= max_speed_param;
  end

  assign active_mode = mode_r;
  assign pulse_position_mode = ppm_r;
  assign position_cmd = pos_r;
  assign speed_cmd = spd_r;
  assign torque_cmd = trq_r;
  assign speed_limit = spd_lim_r;
  assign speed_limit_active = spd_lim_act_r;
  assign torque_limit = trq_lim_r;
  assign torque_limit_active = trq_lim_act_r;
  assign max_speed_limit = msl_r;
  assign monitor1 = mon1_r;
  assign monitor2 = mon2_r;
  // reads of anything but the monitor select return zero
  assign param_rdata = (param_addr == `SDMS_MON_SEL_OFFSET) ? mon_sel_r : 16'h0000;
endmodule

// ### common/sdms_defs.svh
`ifndef SDMS_DEFS_SVH
`define SDMS_DEFS_SVH
`define SDMS_MODE_PT_S 8'h06
`define SDMS_MODE_PT_T 8'h07
`define SDMS_MODE_S_T 8'h0a
`define SDMS_MON_SEL_OFFSET 16'h0006
`define SDMS_MON_SEL_RESET 16'h0000
`define SDMS_MON_SEL_MASK 16'h0077
`define SDMS_MON1_LSB 4
`define SDMS_MON2_LSB 0
`define SDMS_LIM_SPD_EN_BIT 0
`define SDMS_LIM_TRQ_EN_BIT 1
`define SDMS_MON_RESERVED_MIN 3'h6
`endif

// ### common/sdms_pkg.sv
package sdms_pkg;
  typedef enum logic [1:0] {
    SDMS_CTRL_POS,
    SDMS_CTRL_SPD,
    SDMS_CTRL_TRQ
  } sdms_ctrl_t;
  typedef enum logic [2:0] {
    SDMS_MON_SPEED,
    SDMS_MON_TORQUE,
    SDMS_MON_PULSE_FREQ,
    SDMS_MON_SPEED_CMD,
    SDMS_MON_TORQUE_CMD,
    SDMS_MON_BUS_VOLT,
    SDMS_MON_RSVD6,
    SDMS_MON_RSVD7
  } sdms_mon_src_t;
endpackage

// ### rtl/sdms_cmd_sel.sv
`timescale 1ns/1ns
`include "sdms_defs.svh"
module sdms_cmd_sel #(
  parameter int W = 16
) (
  // selection
  input wire logic [1:0] sel,
  input wire logic zero_variant,
  // sources
  input wire logic signed [W-1:0] analog_in,
  input wire logic signed [W-1:0] preset0,
  input wire logic signed [W-1:0] preset1,
  input wire logic signed [W-1:0] preset2,
  // result
  output logic signed [W-1:0] cmd
);
  // both selects off picks analog, or zero in the zero variant
  assign cmd = (sel == 2'b00) ? (zero_variant ? '0 : analog_in) :
               (sel == 2'b01) ? preset0 :
               (sel == 2'b10) ? preset1 : preset2;
endmodule

// ### rtl/sdms_mon_mux.sv
`timescale 1ns/1ns
`include "sdms_defs.svh"
module sdms_mon_mux #(
  parameter int W = 16
) (
  // source code
  input wire logic [2:0] src,
  // candidate values
  input wire logic signed [W-1:0] motor_speed,
  input wire logic signed [W-1:0] motor_torque,
  input wire logic signed [W-1:0] pulse_freq,
  input wire logic signed [W-1:0] speed_cmd,
  input wire logic signed [W-1:0] torque_cmd,
  input wire logic signed [W-1:0] bus_volt,
  // selected value
  output logic signed [W-1:0] value
);
  import sdms_pkg::*;
  // reserved codes drive zero rather than a stale source
  always_comb begin
    case (sdms_mon_src_t'(src))
      SDMS_MON_SPEED: value = motor_speed;
      SDMS_MON_TORQUE: value = motor_torque;
      SDMS_MON_PULSE_FREQ: value = pulse_freq;
      SDMS_MON_SPEED_CMD: value = speed_cmd;
      SDMS_MON_TORQUE_CMD: value = torque_cmd;
      SDMS_MON_BUS_VOLT: value = bus_volt;
      default: value = '0;
    endcase
  end
endmodule

// ### test/sdms_ctrl_model.sv
`timescale 1ns/1ns
module sdms_ctrl_model (
  // clock and request
  input wire logic clk,
  input wire logic [4:0] want,
  // digital inputs of the drive
  output logic mode_switch_in,
  output logic [1:0] speed_preset_sel,
  output logic [1:0] torque_preset_sel
);
  // pins idle at 00 so analog commands are the default; one process owns the pins
  initial begin
    {mode_switch_in, speed_preset_sel, torque_preset_sel} = 5'h00;
    forever begin
      @(posedge clk);
      {mode_switch_in, speed_preset_sel, torque_preset_sel} <= want;
    end
  end
endmodule

// ### test/sdms_properties.sv
`timescale 1ns/1ns
module sdms_properties #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controls
  input wire logic [7:0] control_mode,
  input wire logic [1:0] limit_enable_config,
  input wire logic signed [W-1:0] max_speed_param,
  input wire logic mode_switch_in,
  // parameter port
  input wire logic param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  input wire logic [15:0] param_rdata,
  // results
  input wire sdms_pkg::sdms_ctrl_t active_mode,
  input wire logic pulse_position_mode,
  input wire logic speed_limit_active,
  input wire logic torque_limit_active,
  input wire logic signed [W-1:0] max_speed_limit
);
  import sdms_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_max_speed_wire: assert property (max_speed_limit == $past(max_speed_param))
    else $error("max speed limit off");
  a_pulse_pos_flag: assert property (pulse_position_mode == (active_mode == SDMS_CTRL_POS))
    else $error("pulse position flag off");
  a_spd_lim_mode: assert property (speed_limit_active |-> active_mode == SDMS_CTRL_TRQ)
    else $error("speed limit outside torque mode");
  a_spd_lim_off: assert property (!limit_enable_config[0] [*2] |=> !speed_limit_active)
    else $error("speed limit while disabled");
  a_trq_lim_mode: assert property (torque_limit_active |-> active_mode != SDMS_CTRL_TRQ)
    else $error("torque limit in torque mode");
  a_trq_lim_off: assert property (!limit_enable_config[1] [*2] |=> !torque_limit_active)
    else $error("torque limit while disabled");
  a_rdata_unmapped: assert property (param_addr != 16'h0006 |-> param_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_mon_write: assert property (param_wr && param_addr == 16'h0006 |=>
    param_addr != 16'h0006 || param_rdata == ($past(param_wdata) & 16'h0077))
    else $error("monitor select write lost");
  a_trq_return: assert property ($rose(mode_switch_in) && control_mode == 8'h0a |->
    ##[1:5] active_mode == SDMS_CTRL_TRQ) else $error("torque mode late");
  a_spd_switch: assert property ($fell(mode_switch_in) && control_mode == 8'h0a |->
    ##[1:5] active_mode == SDMS_CTRL_SPD) else $error("speed mode late");
  c_spd_lim: cover property (speed_limit_active);
  c_trq_lim: cover property (torque_limit_active);
  c_dual_trq: cover property (control_mode == 8'h0a && active_mode == SDMS_CTRL_TRQ);
endmodule
bind sdms_top sdms_properties #(.W(W)) i_props (.clk(clk), .reset_n(reset_n), .control_mode(control_mode),
  .limit_enable_config(limit_enable_config), .max_speed_param(max_speed_param), .mode_switch_in(mode_switch_in),
  .param_wr(param_wr), .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
  .active_mode(active_mode), .pulse_position_mode(pulse_position_mode), .speed_limit_active(speed_limit_active),
  .torque_limit_active(torque_limit_active), .max_speed_limit(max_speed_limit));

// ### test/sdms_top_tb.sv
`timescale 1ns/1ns
module sdms_top_tb;
  import sdms_pkg::*;
  logic clk, reset_n, param_wr, zs, zt, ms, ppm, sla, tla;
  logic [7:0] mode;
  logic [1:0] cfg, ss, ts;
  logic [4:0] want;
  logic [15:0] addr, wdata, rdata;
  logic signed [15:0] mx, m1, m2, pos, spd, trq, slim, tlim, msl;
  logic signed [15:0] v[13];
  logic signed [15:0] mvt[8];
  sdms_ctrl_t am;
  int err_total, check_count;

  sdms_ctrl_model i_ctrl (.clk(clk), .want(want), .mode_switch_in(ms), .speed_preset_sel(ss),
    .torque_preset_sel(ts));
  sdms_top i_dut (.clk(clk), .reset_n(reset_n), .control_mode(mode), .zero_speed_variant(zs),
    .zero_torque_variant(zt), .limit_enable_config(cfg), .max_speed_param(mx), .mode_switch_in(ms),
    .speed_preset_sel(ss), .torque_preset_sel(ts), .pulse_position_cmd(v[0]), .analog_speed_in(v[1]),
    .analog_torque_in(v[2]), .speed_preset_params_0(v[3]), .speed_preset_params_1(v[4]),
    .speed_preset_params_2(v[5]), .torque_preset_params_0(v[6]), .torque_preset_params_1(v[7]),
    .torque_preset_params_2(v[8]), .motor_speed(v[9]), .motor_torque(v[10]), .pulse_freq(v[11]),
    .bus_volt(v[12]), .param_wr(param_wr), .param_addr(addr), .param_wdata(wdata), .param_rdata(rdata),
    .active_mode(am), .pulse_position_mode(ppm), .position_cmd(pos), .speed_cmd(spd), .torque_cmd(trq),
    .speed_limit(slim), .speed_limit_active(sla), .torque_limit(tlim), .torque_limit_active(tla),
    .max_speed_limit(msl), .monitor1(m1), .monitor2(m2));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    param_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    param_wr <= 1'b0;
    addr <= 16'h0006;
    #1;
  endtask

  // settle span covers the model edge, two sync edges and the update edge
  task automatic go(input logic [7:0] m, input logic [4:0] w, input logic [1:0] c);
    @(posedge clk);
    mode <= m;
    want <= w;
    cfg <= c;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // select 0 is the analog source, 1..3 the presets
  function automatic logic signed [15:0] pk(int a, int b, int k);
    return k == 0 ? v[a] : v[b + k];
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #10000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    {reset_n, param_wr, zs, zt, cfg, want, wdata} = '0;
    mode = 8'h01;
    addr = 16'h0006;
    mx = 16'h7fff;
    for (int i = 0; i < 13; i++) v[i] = 16'(256 * (i + 1));
    mvt = '{v[9], v[10], v[11], v[1], v[2], v[12], 16'h0000, 16'h0000};
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
    chk(16'(am), 16'(SDMS_CTRL_POS));
    wr(16'h0006, 16'hffff);
    chk(rdata, 16'h0077);
    wr(16'h0007, 16'h0011);
    chk(rdata, 16'h0077);
    for (int c = 0; c < 8; c++) begin
      wr(16'h0006, 16'(c * 16 + 7 - c));
      repeat (4) @(posedge clk);
      #1;
      chk(m1, mvt[c]);
      chk(m2, mvt[7 - c]);
    end
    @(posedge clk);
    zt <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      go(8'h0a, 5'(16 + k * 5), 2'b01);
      chk(16'(am), 16'(SDMS_CTRL_TRQ));
      chk(trq, pk(2, 5, k));
      chk(16'(sla), 16'h0001);
      chk(slim, pk(1, 2, k));
      go(8'h0a, 5'(k * 5), 2'b10);
      chk(16'(am), 16'(SDMS_CTRL_SPD));
      chk(spd, pk(1, 2, k));
      chk(16'(tla), 16'h0001);
      chk(tlim, pk(2, 5, k));
      chk(16'(sla), 16'h0000);
    end
    go(8'h0a, 5'h03, 2'b00);
    chk(16'(tla), 16'h0000);
    chk(tlim, v[2]);
    go(8'h0a, 5'h13, 2'b10);
    chk(16'(tla), 16'h0000);
    go(8'h06, 5'h10, 2'b00);
    chk(16'(am), 16'(SDMS_CTRL_SPD));
    go(8'h06, 5'h00, 2'b10);
    chk(16'(ppm), 16'h0001);
    chk(pos, v[0]);
    chk(16'(tla), 16'h0001);
    go(8'h07, 5'h10, 2'b00);
    chk(16'(am), 16'(SDMS_CTRL_TRQ));
    go(8'h07, 5'h00, 2'b00);
    chk(16'(am), 16'(SDMS_CTRL_POS));
    @(posedge clk);
    mx <= 16'h0050;
    go(8'h0a, 5'h08, 2'b00);
    chk(spd, 16'h0050);
    chk(msl, 16'h0050);
    // zero variants only act outside the dual modes
    @(posedge clk);
    zs <= 1'b1;
    go(8'h01, 5'h00, 2'b00);
    chk(spd, 16'h0000);
    chk(trq, 16'h0000);
    tally_and_finish();
  end
endmodule
